// ==== hw/afsm_consts.svh ====
// Offsets, bit positions and reset values for the amplifier fault status monitor.
`ifndef AFSM_CONSTS_SVH
`define AFSM_CONSTS_SVH

`define AFSM_OFF_CHAN        8'h70
`define AFSM_OFF_GLOB_A      8'h71
`define AFSM_OFF_GLOB_B      8'h72
`define AFSM_OFF_WARN        8'h73
`define AFSM_OFF_MASK        8'h74
`define AFSM_OFF_CLEAR       8'h78

`define AFSM_RST_CHAN        4'h0
`define AFSM_RST_GLOB_A      8'h00
`define AFSM_RST_GLOB_B      3'h0
`define AFSM_RST_MASK        8'h00
`define AFSM_RST_BYTE        8'h00

`define AFSM_CLR_BIT         7
`define AFSM_MASK_WMASK      8'hF7

`define AFSM_CH_LEFT_DC      3
`define AFSM_CH_RIGHT_DC     2
`define AFSM_CH_LEFT_OC      1
`define AFSM_CH_RIGHT_OC     0

`define AFSM_GA_OTP_CRC      7
`define AFSM_GA_COEF_WR      6
`define AFSM_GA_BOOT_LOAD    5
`define AFSM_GA_CLK_FAULT    2
`define AFSM_GA_SUPPLY_OV    1
`define AFSM_GA_SUPPLY_UV    0

`define AFSM_GB_RIGHT_CBC    2
`define AFSM_GB_LEFT_CBC     1
`define AFSM_GB_THERMAL      0

`define AFSM_MK_THERMAL      7
`define AFSM_MK_CLK          4
`define AFSM_MK_SUPPLY       2
`define AFSM_MK_DC           1
`define AFSM_MK_OC           0

`endif

// ==== hw/afsm_pkg.sv ====
// Types shared by the amplifier fault status monitor.
package afsm_pkg;

    typedef struct packed {
        logic otp_crc_error;
        logic filter_coef_write_error_flag;
        logic boot_load_error;
        logic clock_fault;
        logic supply_overvoltage_flag;
        logic supply_undervoltage_flag;
        logic right_cycle_limit_fault_flag;
        logic left_cycle_limit_fault_flag;
        logic thermal_shutdown_flag;
        logic left_dc_fault_flag;
        logic right_dc_fault_flag;
        logic left_overcurrent_flag;
        logic right_overcurrent_flag;
    } afsm_flt_s;

    typedef struct packed {
        logic [3:0] chan;
        logic [7:0] glob_a;
        logic [2:0] glob_b;
    } afsm_stat_s;

endpackage : afsm_pkg

// ==== hw/afsm_monitor.sv ====
// Latched fault status registers, output high-impedance control and fault pin.
`timescale 1ns/1ps
`include "afsm_consts.svh"


module afsm_monitor (
    input  wire logic                clk_in,
    input  wire logic                arst_n_in,
    input  wire logic                ce_in,
    input  wire afsm_pkg::afsm_flt_s fault_cond_in,
    input  wire logic [7:0]          reg_addr_in,
    input  wire logic                reg_wr_in,
    input  wire logic [7:0]          reg_wdata_in,
    input  wire logic                reg_rd_in,
    output logic [7:0]               reg_rdata_out,
    output logic                     reg_rvalid_out,
    output logic                     amp_hiz_out,
    output logic                     fault_out
);

    afsm_pkg::afsm_flt_s sync1_q;
    afsm_pkg::afsm_flt_s sync1_d;
    afsm_pkg::afsm_flt_s sync2_q;
    afsm_pkg::afsm_flt_s sync2_d;
    afsm_pkg::afsm_stat_s stat_q;
    afsm_pkg::afsm_stat_s stat_d;
    logic [7:0]          mask_q;
    logic [7:0]          mask_d;
    logic [7:0]          rdata_q;
    logic [7:0]          rdata_d;
    logic                rvalid_q;
    logic                rvalid_d;
    logic                hiz_q;
    logic                hiz_d;
    logic                fault_q;
    logic                fault_d;
    logic                clr_wr;
    logic [3:0]          chan_ev;
    logic [7:0]          ga_ev;
    logic [2:0]          gb_ev;
    logic                live_auto;

    // Reads back one register byte; unmapped and write-only offsets read zero.
    function automatic logic [7:0] rd_mux(input logic [7:0] addr,
                                           input afsm_pkg::afsm_stat_s st,
                                           input logic [7:0] mk);
        logic [7:0] r;
        r = `AFSM_RST_BYTE;
        unique case (addr)
            `AFSM_OFF_CHAN:   r = {4'h0, st.chan};
            `AFSM_OFF_GLOB_A: r = st.glob_a;
            `AFSM_OFF_GLOB_B: r = {5'h00, st.glob_b};
            `AFSM_OFF_MASK:   r = mk;
            default:          r = `AFSM_RST_BYTE;
        endcase
        return r;
    endfunction

    // Computes the fault pin level from status and mask.
    function automatic logic report(input afsm_pkg::afsm_stat_s st,
                                    input logic [7:0] mk);
        logic r;
        r = 1'b0;
        if ((st.chan[`AFSM_CH_LEFT_DC] || st.chan[`AFSM_CH_RIGHT_DC]) && !mk[`AFSM_MK_DC]) begin
            r = 1'b1;
        end
        if ((st.chan[`AFSM_CH_LEFT_OC] || st.chan[`AFSM_CH_RIGHT_OC]) && !mk[`AFSM_MK_OC]) begin
            r = 1'b1;
        end
        if (st.glob_a[`AFSM_GA_CLK_FAULT] && !mk[`AFSM_MK_CLK]) begin
            r = 1'b1;
        end
        if ((st.glob_a[`AFSM_GA_SUPPLY_OV] || st.glob_a[`AFSM_GA_SUPPLY_UV]) && !mk[`AFSM_MK_SUPPLY]) begin
            r = 1'b1;
        end
        if (st.glob_b[`AFSM_GB_THERMAL] && !mk[`AFSM_MK_THERMAL]) begin
            r = 1'b1;
        end
        if (st.glob_b[`AFSM_GB_RIGHT_CBC] || st.glob_b[`AFSM_GB_LEFT_CBC]) begin
            r = 1'b1;
        end
        return r;
    endfunction

    // Two-stage synchroniser for the analog fault conditions.
    always_comb begin
        sync1_d = fault_cond_in;
        sync2_d = sync1_q;
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else if (ce_in) begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    // Latched status, mask register and output controls.
    always_comb begin
        clr_wr = reg_wr_in && (reg_addr_in == `AFSM_OFF_CLEAR) && reg_wdata_in[`AFSM_CLR_BIT];
        chan_ev = '0;
        chan_ev[`AFSM_CH_LEFT_DC]  = sync2_q.left_dc_fault_flag;
        chan_ev[`AFSM_CH_RIGHT_DC] = sync2_q.right_dc_fault_flag;
        chan_ev[`AFSM_CH_LEFT_OC]  = sync2_q.left_overcurrent_flag;
        chan_ev[`AFSM_CH_RIGHT_OC] = sync2_q.right_overcurrent_flag;
        ga_ev = '0;
        ga_ev[`AFSM_GA_OTP_CRC]   = sync2_q.otp_crc_error;
        ga_ev[`AFSM_GA_COEF_WR]   = sync2_q.filter_coef_write_error_flag;
        ga_ev[`AFSM_GA_BOOT_LOAD] = sync2_q.boot_load_error;
        ga_ev[`AFSM_GA_CLK_FAULT] = sync2_q.clock_fault;
        ga_ev[`AFSM_GA_SUPPLY_OV] = sync2_q.supply_overvoltage_flag;
        ga_ev[`AFSM_GA_SUPPLY_UV] = sync2_q.supply_undervoltage_flag;
        gb_ev = '0;
        gb_ev[`AFSM_GB_RIGHT_CBC] = sync2_q.right_cycle_limit_fault_flag;
        gb_ev[`AFSM_GB_LEFT_CBC]  = sync2_q.left_cycle_limit_fault_flag;
        gb_ev[`AFSM_GB_THERMAL]   = sync2_q.thermal_shutdown_flag;
        // A new event wins over a clear in the same cycle.
        stat_d = clr_wr ? '0 : stat_q;
        stat_d.chan   = stat_d.chan | chan_ev;
        stat_d.glob_a = stat_d.glob_a | ga_ev;
        stat_d.glob_b = stat_d.glob_b | gb_ev;
        mask_d = mask_q;
        if (reg_wr_in && (reg_addr_in == `AFSM_OFF_MASK)) begin
            mask_d = reg_wdata_in & `AFSM_MASK_WMASK;
        end
        // Auto-recovering faults hold Hi-Z only while the condition lasts.
        live_auto = sync2_q.clock_fault || sync2_q.supply_overvoltage_flag ||
                    sync2_q.supply_undervoltage_flag || sync2_q.thermal_shutdown_flag;
        hiz_d = (|stat_d.chan) || live_auto;
        fault_d = report(stat_d, mask_d);
        rvalid_d = reg_rd_in;
        rdata_d = reg_rd_in ? rd_mux(reg_addr_in, stat_q, mask_q) : rdata_q;
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            stat_q.chan   <= `AFSM_RST_CHAN;
            stat_q.glob_a <= `AFSM_RST_GLOB_A;
            stat_q.glob_b <= `AFSM_RST_GLOB_B;
            mask_q        <= `AFSM_RST_MASK;
            rdata_q       <= `AFSM_RST_BYTE;
            rvalid_q      <= 1'b0;
            hiz_q         <= 1'b0;
            fault_q       <= 1'b0;
        end else if (ce_in) begin
            stat_q   <= stat_d;
            mask_q   <= mask_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
            hiz_q    <= hiz_d;
            fault_q  <= fault_d;
        end
    end

    assign reg_rdata_out  = rdata_q;
    assign reg_rvalid_out = rvalid_q;
    assign amp_hiz_out    = hiz_q;
    assign fault_out      = fault_q;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);

    sequence s_clear;
        ce_in && reg_wr_in && (reg_addr_in == `AFSM_OFF_CLEAR) && reg_wdata_in[`AFSM_CLR_BIT];
    endsequence

    sequence s_dc_left_seen;
        ce_in && sync2_q.left_dc_fault_flag;
    endsequence

    sequence s_idle_ce;
        ce_in && !reg_wr_in;
    endsequence

    property p_left_dc;
        s_dc_left_seen |=> stat_q.chan[`AFSM_CH_LEFT_DC] && amp_hiz_out;
    endproperty
    a_left_dc: assert property (p_left_dc) else $error("Left DC fault not latched.");

    property p_right_dc;
        ce_in && sync2_q.right_dc_fault_flag |=> stat_q.chan[`AFSM_CH_RIGHT_DC] && amp_hiz_out;
    endproperty
    a_right_dc: assert property (p_right_dc) else $error("Right DC fault not latched.");

    property p_left_oc;
        ce_in && sync2_q.left_overcurrent_flag && !mask_q[`AFSM_MK_OC] && !reg_wr_in
            |=> stat_q.chan[`AFSM_CH_LEFT_OC] && fault_out && amp_hiz_out;
    endproperty
    a_left_oc: assert property (p_left_oc) else $error("Left over-current not reported.");

    property p_right_oc;
        ce_in && sync2_q.right_overcurrent_flag |=> stat_q.chan[`AFSM_CH_RIGHT_OC] && amp_hiz_out;
    endproperty
    a_right_oc: assert property (p_right_oc) else $error("Right over-current not latched.");

    property p_hold;
        s_idle_ce |=> ((stat_q.chan | $past(stat_q.chan)) == stat_q.chan)
            && ((stat_q.glob_a | $past(stat_q.glob_a)) == stat_q.glob_a)
            && ((stat_q.glob_b | $past(stat_q.glob_b)) == stat_q.glob_b);
    endproperty
    a_hold: assert property (p_hold) else $error("Latched fault dropped without clear.");

    property p_clear;
        s_clear and (sync2_q == '0) |=> (stat_q == '0) && !fault_out && !amp_hiz_out;
    endproperty
    a_clear: assert property (p_clear) else $error("Clear write left faults set.");

    property p_clk_fault;
        ce_in && sync2_q.clock_fault |=> stat_q.glob_a[`AFSM_GA_CLK_FAULT] && amp_hiz_out;
    endproperty
    a_clk_fault: assert property (p_clk_fault) else $error("Clock fault not handled.");

    property p_recover;
        ce_in && (sync2_q == '0) && (stat_q.chan == '0) && !clr_wr |=> !amp_hiz_out;
    endproperty
    a_recover: assert property (p_recover) else $error("Outputs stay Hi-Z after recovery.");

    property p_ov;
        ce_in && sync2_q.supply_overvoltage_flag |=> stat_q.glob_a[`AFSM_GA_SUPPLY_OV] && amp_hiz_out;
    endproperty
    a_ov: assert property (p_ov) else $error("Over-voltage not handled.");

    property p_uv;
        ce_in && sync2_q.supply_undervoltage_flag |=> stat_q.glob_a[`AFSM_GA_SUPPLY_UV] && amp_hiz_out;
    endproperty
    a_uv: assert property (p_uv) else $error("Under-voltage not handled.");

    property p_thermal;
        ce_in && sync2_q.thermal_shutdown_flag |=> stat_q.glob_b[`AFSM_GB_THERMAL] && amp_hiz_out;
    endproperty
    a_thermal: assert property (p_thermal) else $error("Thermal shutdown not handled.");

    property p_cbc;
        ce_in && sync2_q.right_cycle_limit_fault_flag |=> stat_q.glob_b[`AFSM_GB_RIGHT_CBC] && fault_out;
    endproperty
    a_cbc: assert property (p_cbc) else $error("Cycle limit fault not reported.");

    property p_cbc_left;
        ce_in && sync2_q.left_cycle_limit_fault_flag |=> stat_q.glob_b[`AFSM_GB_LEFT_CBC] && fault_out;
    endproperty
    a_cbc_left: assert property (p_cbc_left) else $error("Left cycle limit fault not reported.");

    property p_otp;
        ce_in && sync2_q.otp_crc_error |=> stat_q.glob_a[`AFSM_GA_OTP_CRC];
    endproperty
    a_otp: assert property (p_otp) else $error("Memory integrity error not flagged.");

    property p_coef;
        ce_in && sync2_q.filter_coef_write_error_flag |=> stat_q.glob_a[`AFSM_GA_COEF_WR];
    endproperty
    a_coef: assert property (p_coef) else $error("Coefficient write error not flagged.");

    property p_boot;
        ce_in && sync2_q.boot_load_error |=> stat_q.glob_a[`AFSM_GA_BOOT_LOAD];
    endproperty
    a_boot: assert property (p_boot) else $error("Boot load error not flagged.");

    property p_chan_read;
        ce_in && reg_rd_in && (reg_addr_in == `AFSM_OFF_CHAN)
            |=> reg_rvalid_out && (reg_rdata_out[7:4] == 4'h0) && (reg_rdata_out[3:0] == $past(stat_q.chan));
    endproperty
    a_chan_read: assert property (p_chan_read) else $error("Channel register read wrong.");

    property p_dc_mask;
        ce_in && mask_q[`AFSM_MK_DC] && !reg_wr_in && ($past(fault_out) == 1'b0) && sync2_q.left_dc_fault_flag
            && (sync2_q.clock_fault == 1'b0) && ((stat_q.glob_a | stat_q.glob_b) == 8'h00)
            && (stat_q.chan[1:0] == 2'h0) && !sync2_q.left_overcurrent_flag && !sync2_q.right_overcurrent_flag
            && !sync2_q.supply_overvoltage_flag && !sync2_q.supply_undervoltage_flag
            && !sync2_q.thermal_shutdown_flag && !sync2_q.right_cycle_limit_fault_flag
            && !sync2_q.left_cycle_limit_fault_flag
            |=> stat_q.chan[`AFSM_CH_LEFT_DC] && !fault_out;
    endproperty
    a_dc_mask: assert property (p_dc_mask) else $error("Masked DC fault reached the pin.");

    property p_pin;
        ce_in ##1 (stat_q == '0) |-> !fault_out;
    endproperty
    a_pin: assert property (p_pin) else $error("Fault pin set with no fault.");

    property p_freeze;
        !ce_in |=> $stable(stat_q) && $stable(amp_hiz_out) && $stable(fault_out) && $stable(reg_rvalid_out);
    endproperty
    a_freeze: assert property (p_freeze) else $error("State moved while clock enable was low.");

endmodule : afsm_monitor

// ==== verification/afsm_host_model.sv ====
// Control-bus host model that issues register reads and writes.
`timescale 1ns/1ps

module afsm_host_model (
    input  wire logic       clk_in,
    input  wire logic [7:0] rdata_in,
    input  wire logic       rvalid_in,
    output logic      [7:0] addr_out,
    output logic            wr_out,
    output logic      [7:0] wdata_out,
    output logic            rd_out
);
    initial begin
        addr_out  = 8'h00;
        wr_out    = 1'b0;
        wdata_out = 8'h00;
        rd_out    = 1'b0;
    end

    // One-cycle write strobe; released data is inverted so it never looks valid.
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_in);
        addr_out  = addr;
        wdata_out = data;
        wr_out    = 1'b1;
        @(negedge clk_in);
        wr_out    = 1'b0;
        wdata_out = ~data;
    endtask

    // One-cycle read strobe; the answer is taken in the cycle after the taking edge.
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
        @(negedge clk_in);
        addr_out = addr;
        rd_out   = 1'b1;
        @(negedge clk_in);
        rd_out   = 1'b0;
        addr_out = ~addr;
        ok       = rvalid_in;
        data     = rdata_in;
    endtask
endmodule // afsm_host_model

// ==== verification/amp_fault_status_monitor_bench.sv ====
// Self-checking bench for the amplifier fault status monitor.
`timescale 1ns/1ps

module amp_fault_status_monitor_bench;
    logic                clk;
    logic                arst_n;
    logic                ce;
    afsm_pkg::afsm_flt_s cond;
    logic [7:0]          addr;
    logic                wr;
    logic [7:0]          wdata;
    logic                rd;
    logic [7:0]          rdata;
    logic                rvalid;
    logic                hiz;
    logic                flt;
    int                  err_count;
    int                  n_tests;

    afsm_monitor u_dut (.clk_in(clk), .arst_n_in(arst_n), .ce_in(ce), .fault_cond_in(cond),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .amp_hiz_out(hiz), .fault_out(flt));

    afsm_host_model u_host (.clk_in(clk), .rdata_in(rdata), .rvalid_in(rvalid), .addr_out(addr),
        .wr_out(wr), .wdata_out(wdata), .rd_out(rd));

    always #4 clk = ~clk;

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        u_host.read_reg(a, d, ok);
        check({7'h00, ok}, 8'h01);
        check(d, exp);
    endtask

    task automatic run_fault(input int idx, input logic [7:0] a, input logic [7:0] v,
                             input logic hl, input logic ha, input logic fl);
        @(negedge clk);
        cond = afsm_pkg::afsm_flt_s'(13'h0001 << idx);
        repeat (3) @(negedge clk);
        check({6'h00, hiz, flt}, {6'h00, hl, fl});
        read_check(a, v);
        @(negedge clk);
        cond = '0;
        repeat (3) @(negedge clk);
        check({6'h00, hiz, flt}, {6'h00, ha, fl});
        read_check(a, v);
        u_host.write_reg(8'h78, 8'h80);
        read_check(a, 8'h00);
        check({6'h00, hiz, flt}, 8'h00);
    endtask

    task automatic t_reset;
        logic [7:0] a [6] = '{8'h70, 8'h71, 8'h72, 8'h73, 8'h78, 8'h55};
        check({6'h00, hiz, flt}, 8'h00);
        foreach (a[i]) read_check(a[i], 8'h00);
        u_host.write_reg(8'h70, 8'hFF);
        read_check(8'h70, 8'h00);
    endtask

    task automatic t_channel;
        run_fault(3, 8'h70, 8'h08, 1'b1, 1'b1, 1'b1);
        run_fault(2, 8'h70, 8'h04, 1'b1, 1'b1, 1'b1);
        run_fault(1, 8'h70, 8'h02, 1'b1, 1'b1, 1'b1);
        run_fault(0, 8'h70, 8'h01, 1'b1, 1'b1, 1'b1);
    endtask

    task automatic t_global;
        run_fault(9, 8'h71, 8'h04, 1'b1, 1'b0, 1'b1);
        run_fault(8, 8'h71, 8'h02, 1'b1, 1'b0, 1'b1);
        run_fault(7, 8'h71, 8'h01, 1'b1, 1'b0, 1'b1);
        run_fault(4, 8'h72, 8'h01, 1'b1, 1'b0, 1'b1);
        run_fault(6, 8'h72, 8'h04, 1'b0, 1'b0, 1'b1);
        run_fault(5, 8'h72, 8'h02, 1'b0, 1'b0, 1'b1);
        run_fault(12, 8'h71, 8'h80, 1'b0, 1'b0, 1'b0);
        run_fault(11, 8'h71, 8'h40, 1'b0, 1'b0, 1'b0);
        run_fault(10, 8'h71, 8'h20, 1'b0, 1'b0, 1'b0);
    endtask

    task automatic t_mask;
        u_host.write_reg(8'h74, 8'h02);
        read_check(8'h74, 8'h02);
        run_fault(3, 8'h70, 8'h08, 1'b1, 1'b1, 1'b0);
        u_host.write_reg(8'h74, 8'hFF);
        read_check(8'h74, 8'hF7);
        run_fault(2, 8'h70, 8'h04, 1'b1, 1'b1, 1'b0);
        run_fault(1, 8'h70, 8'h02, 1'b1, 1'b1, 1'b0);
        run_fault(9, 8'h71, 8'h04, 1'b1, 1'b0, 1'b0);
        run_fault(8, 8'h71, 8'h02, 1'b1, 1'b0, 1'b0);
        run_fault(4, 8'h72, 8'h01, 1'b1, 1'b0, 1'b0);
        run_fault(6, 8'h72, 8'h04, 1'b0, 1'b0, 1'b1);
        u_host.write_reg(8'h74, 8'h00);
    endtask

    task automatic t_clear_live;
        @(negedge clk);
        cond = afsm_pkg::afsm_flt_s'(13'h0001);
        repeat (3) @(negedge clk);
        u_host.write_reg(8'h78, 8'h80);
        read_check(8'h70, 8'h01);
        cond = '0;
        repeat (3) @(negedge clk);
        u_host.write_reg(8'h78, 8'h7F);
        read_check(8'h70, 8'h01);
        u_host.write_reg(8'h78, 8'h80);
        read_check(8'h70, 8'h00);
        check({6'h00, hiz, flt}, 8'h00);
    endtask

    task automatic t_freeze;
        @(negedge clk);
        ce   = 1'b0;
        cond = afsm_pkg::afsm_flt_s'(13'h0008);
        repeat (4) @(negedge clk);
        check({6'h00, hiz, flt}, 8'h00);
        ce = 1'b1;
        repeat (3) @(negedge clk);
        check({6'h00, hiz, flt}, 8'h03);
        cond = '0;
        read_check(8'h70, 8'h08);
        u_host.write_reg(8'h78, 8'h80);
        read_check(8'h70, 8'h00);
    endtask

    task automatic t_reset_mid;
        @(negedge clk);
        cond = afsm_pkg::afsm_flt_s'(13'h0002);
        repeat (3) @(negedge clk);
        check({6'h00, hiz, flt}, 8'h03);
        cond = '0;
        u_host.write_reg(8'h74, 8'hFF);
        arst_n = 1'b0;
        repeat (4) @(negedge clk);
        arst_n = 1'b1;
        check({6'h00, hiz, flt}, 8'h00);
        read_check(8'h70, 8'h00);
        read_check(8'h74, 8'h00);
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #200000;
        err_count++;
        conclude();
    end

    initial begin
        clk       = 1'b0;
        arst_n    = 1'b0;
        ce        = 1'b1;
        cond      = '0;
        err_count = 0;
        n_tests   = 0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        t_reset();
        t_channel();
        t_global();
        t_mask();
        t_clear_live();
        t_freeze();
        t_reset_mid();
        conclude();
    end
endmodule // amp_fault_status_monitor_bench
